// ==== dv/asc_adc_ctl_chk.sv ====
`timescale 1ns/10ps
module asc_adc_ctl_chk #(
    parameter int DATA_PERIOD_CYC = 64,
    parameter int POR_CYC = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Pins
    input wire logic rst_pin_n_i,
    input wire logic power_down_n_i,
    input wire logic [1:0] supply_good_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input logic dout_o,
    input logic dout_oe_o,
    input logic data_ready_n_o,
    input logic analog_en_o,
    input logic cfg_fir_o,
    input logic [2:0] cfg_rate_o
);
    localparam longint DR_L = (longint'(DATA_PERIOD_CYC) * 64'd6298046875) / 64'd100000000;
    localparam int DR_CYC = int'(DR_L) + 468;
    logic [31:0] por_cnt_r;
    logic [31:0] rel_cnt_r;
    wire logic sup_ok = (supply_good_i == 2'b11);
    wire logic dev_up = sup_ok && rst_pin_n_i && power_down_n_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !sup_ok) begin
            por_cnt_r <= '0;
        end else if (por_cnt_r < POR_CYC) begin
            por_cnt_r <= por_cnt_r + 32'h1;
        end
    end
    // Any restart only lengthens the wait, so a lower bound is safe
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !dev_up) begin
            rel_cnt_r <= '0;
        end else if (rel_cnt_r < DR_CYC) begin
            rel_cnt_r <= rel_cnt_r + 32'h1;
        end
    end
    property p_oe_off; cs_n_i [*4] |-> !dout_oe_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("dout driven with cs high");
    property p_oe_on; !cs_n_i [*5] |-> dout_oe_o; endproperty
    a_oe_on: assert property (p_oe_on) else $error("dout not driven with cs low");
    property p_rst_pin; !rst_pin_n_i ##1 !rst_pin_n_i |-> ##3 data_ready_n_o [*2]; endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("ready low in pin reset");
    property p_pd;
        !power_down_n_i [*5] |-> !analog_en_o && cfg_fir_o && (cfg_rate_o == 3'h2);
    endproperty
    a_pd: assert property (p_pd) else $error("power-down state wrong");
    property p_data_ready_n_pulse; $rose(data_ready_n_o) && cs_n_i |-> data_ready_n_o [*4]; endproperty
    a_data_ready_n_pulse: assert property (p_data_ready_n_pulse) else $error("ready high pulse short");
    property p_dout_hold;
        (sclk_i && !cs_n_i && data_ready_n_o) [*8] |-> $stable(dout_o);
    endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("dout moved while sclk high");
    property p_por; por_cnt_r < POR_CYC |-> data_ready_n_o; endproperty
    a_por: assert property (p_por) else $error("ready before power-on count");
    property p_dr_time; rel_cnt_r < DR_CYC |-> data_ready_n_o; endproperty
    a_dr_time: assert property (p_dr_time) else $error("first data too early");
endmodule
bind asc_adc_ctl asc_adc_ctl_chk #(.DATA_PERIOD_CYC(DATA_PERIOD_CYC), .POR_CYC(POR_CYC))
    i_asc_adc_ctl_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .rst_pin_n_i(rst_pin_n_i),
    .power_down_n_i(power_down_n_i), .supply_good_i(supply_good_i), .cs_n_i(cs_n_i),
    .sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .data_ready_n_o(data_ready_n_o),
    .analog_en_o(analog_en_o), .cfg_fir_o(cfg_fir_o), .cfg_rate_o(cfg_rate_o));

// ==== dv/asc_host_model.sv ====
`timescale 1ns/10ps
module asc_host_model (
    // Clock
    input wire logic core_clk_i,
    // Serial pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o,
    input wire logic dout_i
);
    // Half of a 160 ns serial period
    localparam int HALF_CYC = 20;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic sel(input logic en);
        cs_n_o = !en;
        tick(HALF_CYC);
    endtask
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            din_o = b[i];
            tick(HALF_CYC);
            sclk_o = 1'b1;
            tick(HALF_CYC);
            sclk_o = 1'b0;
        end
        din_o = 1'b0;
    endtask
    // Data taken at the rise, device moves it after the fall
    task automatic read_word(output logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            sclk_o = 1'b1;
            w[i] = dout_i;
            tick(HALF_CYC);
            sclk_o = 1'b0;
            tick(HALF_CYC);
        end
    endtask
endmodule

// ==== dv/tb_asc_adc_ctl.sv ====
`timescale 1ns/10ps
`include "asc_defines.svh"
module tb_asc_adc_ctl;
    localparam int DPC = 64;
    typedef struct packed { logic [31:0] word; logic [31:0] exp; } asc_tb_row_s;
    asc_tb_row_s rows [4] = '{'{32'h0, 32'h0}, '{32'hffffffff, 32'hffffffff},
        '{32'h80000001, 32'h80000001}, '{32'ha5c30f18, 32'ha5c30f18}};
    logic core_clk_i, rst_i, rst_pin_n, power_down_n, sync, cont_sync, conv_valid;
    logic [1:0] supply_good;
    logic [31:0] conv_data;
    logic cs_n, sclk, din, dout, dout_oe, data_ready_n, conv_ready;
    logic filter_restart, analog_en, cfg_fir;
    logic [2:0] cfg_rate;
    logic [31:0] w;
    int err_total = 0;
    int tests_run = 0;
    int restarts = 0;
    int falls = 0;
    int rs, acc;
    logic ok, data_ready_n_d;
    always #2 core_clk_i = ~core_clk_i;
    asc_adc_ctl #(.DATA_PERIOD_CYC(DPC), .POR_CYC(16)) i_asc_adc_ctl (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .rst_pin_n_i(rst_pin_n), .power_down_n_i(power_down_n), .sync_i(sync),
        .cont_sync_i(cont_sync), .supply_good_i(supply_good), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .data_ready_n_o(data_ready_n),
        .conv_data_i(conv_data), .conv_valid_i(conv_valid), .conv_ready_o(conv_ready),
        .filter_restart_o(filter_restart), .analog_en_o(analog_en), .cfg_fir_o(cfg_fir),
        .cfg_rate_o(cfg_rate));
    asc_host_model i_asc_host_model (.core_clk_i(core_clk_i), .cs_n_o(cs_n), .sclk_o(sclk),
        .din_o(din), .dout_i(dout));
    // Counted mid-cycle, where outputs are settled
    always @(negedge core_clk_i) begin
        if (filter_restart === 1'b1) restarts++;
        if (data_ready_n === 1'b0 && data_ready_n_d === 1'b1) falls++;
        data_ready_n_d = data_ready_n;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic push(input logic [31:0] v);
        conv_data = v;
        conv_valid = 1'b1;
        while (conv_ready !== 1'b1) tick(1);
        tick(1);
        conv_valid = 1'b0;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] arg);
        i_asc_host_model.sel(1'b1);
        i_asc_host_model.send_bits(op, 8);
        if (op == `ASC_OP_WREG) begin
            i_asc_host_model.send_bits(8'h00, 8);
            i_asc_host_model.send_bits(arg, 8);
        end
        i_asc_host_model.sel(1'b0);
    endtask
    // Word through the buffer, then out on the serial port
    task automatic read_one(input logic [31:0] v, output logic [31:0] got);
        int n;
        n = 0;
        i_asc_host_model.sel(1'b1);
        push(v);
        while (data_ready_n !== 1'b0 && n < 6000) begin
            tick(1);
            n++;
        end
        chk(n < 6000, 1'b1);
        tick(2);
        i_asc_host_model.read_word(got);
        i_asc_host_model.sel(1'b0);
    endtask
    initial begin
        repeat (60000) @(posedge core_clk_i);
        err_total++;
        results();
    end
    initial begin
        core_clk_i = 1'b0;
        {rst_i, rst_pin_n, power_down_n, sync, cont_sync, conv_valid} = 6'b111000;
        supply_good = 2'b00;
        conv_data = 32'h0;
        tick(12);
        rst_i = 1'b0;
        tick(8);
        supply_good = 2'b11;
        tick(40);
        chk(cfg_fir, 1'b1);
        chk(cfg_rate, 3'h2);
        foreach (rows[k]) begin
            read_one(rows[k].word, w);
            chk(w, rows[k].exp);
        end
        rs = restarts;
        sync = 1'b1;
        tick(8);
        sync = 1'b0;
        tick(20);
        chk(restarts - rs, 1);
        rs = restarts;
        cmd(`ASC_OP_SYNC, 8'h00);
        chk(restarts - rs, 1);
        cont_sync = 1'b1;
        tick(20);
        rs = restarts;
        repeat (4) begin
            sync = 1'b1;
            tick(8);
            sync = 1'b0;
            tick(2 * DPC - 8);
        end
        chk(restarts - rs, 1);
        tick(DPC / 2);
        sync = 1'b1;
        tick(8);
        sync = 1'b0;
        tick(20);
        chk(restarts - rs, 2);
        cmd(`ASC_OP_WREG, 8'h05);
        chk(cfg_rate, 3'h5);
        read_one(32'h12345678, w);
        chk(w, 32'h0);
        // Pin alignment lost after the write: edges ignored until wake
        rs = restarts;
        sync = 1'b1;
        tick(8);
        sync = 1'b0;
        tick(20);
        chk(restarts - rs, 0);
        i_asc_host_model.sel(1'b1);
        i_asc_host_model.send_bits(`ASC_OP_STANDBY, 8);
        i_asc_host_model.tick(3);
        i_asc_host_model.send_bits(`ASC_OP_WAKE, 8);
        sync = 1'b1;
        tick(8);
        sync = 1'b0;
        tick(20);
        chk(restarts - rs, 2);
        i_asc_host_model.sel(1'b0);
        cont_sync = 1'b0;
        i_asc_host_model.sel(1'b1);
        i_asc_host_model.send_bits(`ASC_OP_STANDBY, 8);
        tick(20);
        chk(analog_en, 1'b0);
        chk(cfg_rate, 3'h5);
        i_asc_host_model.sel(1'b0);
        chk(analog_en, 1'b1);
        // Half a reset opcode, cut off by chip select
        i_asc_host_model.sel(1'b1);
        i_asc_host_model.send_bits(`ASC_OP_RESET, 4);
        i_asc_host_model.sel(1'b0);
        chk(cfg_rate, 3'h5);
        cmd(`ASC_OP_RESET, 8'h00);
        chk(cfg_rate, 3'h2);
        cmd(`ASC_OP_WREG, 8'h05);
        rst_pin_n = 1'b0;
        tick(2);
        rst_pin_n = 1'b1;
        tick(10);
        chk(cfg_rate, 3'h2);
        cmd(`ASC_OP_WREG, 8'h05);
        power_down_n = 1'b0;
        tick(30);
        power_down_n = 1'b1;
        tick(20);
        chk(cfg_rate, 3'h2);
        chk(cfg_fir, 1'b1);
        cmd(`ASC_OP_STOP_CONTINUOUS_READ_CMD, 8'h00);
        acc = 0;
        conv_valid = 1'b1;
        for (int c = 0; c < 12; c++) begin
            conv_data = 32'hc0de0000 + acc;
            ok = (conv_ready === 1'b1);
            tick(1);
            if (ok) acc++;
        end
        chk(acc, 2);
        chk(conv_ready, 1'b0);
        rs = falls;
        push(32'hc0de0002);
        tick(5 * DPC);
        chk(falls - rs, 3);
        i_asc_host_model.sel(1'b1);
        i_asc_host_model.read_word(w);
        i_asc_host_model.sel(1'b0);
        chk(w, 32'hc0de0002);
        results();
    end
endmodule

// ==== logic/asc_adc_ctl.sv ====
`timescale 1ns/10ps
`include "asc_defines.svh"
module asc_adc_ctl #(
    parameter int DATA_PERIOD_CYC = `ASC_DATA_PERIOD_CYC,
    parameter int POR_CYC = `ASC_POR_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Control pins
    input wire logic rst_pin_n_i,
    input wire logic power_down_n_i,
    input wire logic sync_i,
    input wire logic cont_sync_i,
    input wire logic [1:0] supply_good_i,
    // Serial pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    output logic data_ready_n_o,
    // Conversion stream
    input wire logic [31:0] conv_data_i,
    input wire logic conv_valid_i,
    output logic conv_ready_o,
    // Core control
    output logic filter_restart_o,
    output logic analog_en_o,
    output logic cfg_fir_o,
    output logic [2:0] cfg_rate_o
);
    localparam int DR_FRAC_CYC =
        int'((64'(DATA_PERIOD_CYC) * `ASC_DR_PER_NUM) / `ASC_DR_PER_DEN);
    localparam logic [31:0] DR_CYC = 32'(DR_FRAC_CYC + `ASC_DR_CLK_CYC);
    localparam logic [31:0] WAKE_DR_CYC = DR_CYC - 32'(`ASC_WAKE_TRIM_CYC);
    localparam logic [31:0] PERIOD_LAST = 32'(DATA_PERIOD_CYC - 1);
    localparam logic [31:0] POR_LAST = 32'(POR_CYC - 1);
    localparam logic [7:0] CFG_RST = `ASC_CFG_RST;

    asc_ser_if ser ();

    asc_spi_port u_spi (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .cs_n_i(cs_n_i),
        .sclk_i(sclk_i),
        .din_i(din_i),
        .dout_o(dout_o),
        .dout_oe_o(dout_oe_o),
        .ser(ser.port)
    );

    // Pin synchronisers
    logic [5:0] pin_a_r;
    logic [5:0] pin_b_r;
    wire [5:0] pin_raw = {cont_sync_i, sync_i, supply_good_i, power_down_n_i, rst_pin_n_i};
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge core_clk_i) begin
                pin_a_r[gi] <= pin_raw[gi];
                pin_b_r[gi] <= pin_a_r[gi];
            end
        end
    endgenerate
    wire rst_pin_s = pin_b_r[0];
    wire power_down_n_n_s = pin_b_r[1];
    wire [1:0] supply_s = pin_b_r[3:2];
    wire sync_s = pin_b_r[4];
    wire cont_s = pin_b_r[5];

    // Power-on reset
    logic [31:0] por_cnt_r;
    logic por_done_r;
    wire supply_ok = &supply_s;
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !supply_ok) begin
            por_cnt_r <= 32'h0;
            por_done_r <= 1'b0;
        end else if (!por_done_r) begin
            por_done_r <= (por_cnt_r == POR_LAST);
            por_cnt_r <= por_cnt_r + 32'h1;
        end
    end

    // Serial command decode
    function automatic logic is_op(input logic [7:0] b, input logic [7:0] op);
        return b == op;
    endfunction

    logic [1:0] wreg_left_r;
    logic cmd_rst_r;
    wire rx_cmd = ser.rx_vld && (wreg_left_r == 2'h0);
    wire op_wake = rx_cmd && is_op(ser.rx_byte, `ASC_OP_WAKE);
    wire op_standby = rx_cmd && is_op(ser.rx_byte, `ASC_OP_STANDBY);
    wire op_reset = rx_cmd && is_op(ser.rx_byte, `ASC_OP_RESET);
    wire op_sync = rx_cmd && is_op(ser.rx_byte, `ASC_OP_SYNC);
    wire op_rdatac = rx_cmd && is_op(ser.rx_byte, `ASC_OP_RDATAC);
    wire op_stop_continuous_read_cmd = rx_cmd && is_op(ser.rx_byte, `ASC_OP_STOP_CONTINUOUS_READ_CMD);
    wire op_wreg = rx_cmd && is_op(ser.rx_byte, `ASC_OP_WREG);
    wire reg_wr = ser.rx_vld && (wreg_left_r == 2'h1);

    // Pin reset held while low, power-down resets settings too
    wire dev_rst = rst_i || !por_done_r || !rst_pin_s || !power_down_n_n_s || cmd_rst_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cmd_rst_r <= 1'b0;
        end else begin
            cmd_rst_r <= op_reset;
        end
    end

    // Register write takes opcode, count byte, then one data byte
    logic [7:0] cfg_r;
    logic stop_continuous_read_cmd_r;
    always_ff @(posedge core_clk_i) begin
        if (dev_rst) begin
            wreg_left_r <= 2'h0;
            cfg_r <= `ASC_CFG_RST;
            stop_continuous_read_cmd_r <= 1'b0;
        end else if (ser.cs_rise) begin
            wreg_left_r <= 2'h0;
            stop_continuous_read_cmd_r <= op_stop_continuous_read_cmd;
        end else begin
            if (op_wreg) begin
                wreg_left_r <= 2'h2;
            end else if (ser.rx_vld && wreg_left_r != 2'h0) begin
                wreg_left_r <= wreg_left_r - 2'h1;
            end
            if (reg_wr) begin
                cfg_r <= ser.rx_byte;
            end
            if (op_stop_continuous_read_cmd) begin
                stop_continuous_read_cmd_r <= 1'b1;
            end else if (op_rdatac) begin
                stop_continuous_read_cmd_r <= 1'b0;
            end
        end
    end

    // Sync edge spacing, modulo the conversion period
    logic sync_d_r;
    logic [31:0] since_edge_r;
    logic armed_r;
    logic pin_lost_r;
    wire sync_edge = sync_s && !sync_d_r;
    wire spacing_whole = (since_edge_r == 32'h0);
    wire first_edge = cont_s && sync_edge && !armed_r && !pin_lost_r;
    wire pulse_sync = (!cont_s && sync_edge) || op_sync || first_edge;
    wire edge_resync = cont_s && sync_edge && armed_r && !pin_lost_r && !spacing_whole;
    wire wr_resync = cont_s && reg_wr;
    wire cont_resync = edge_resync || wr_resync;

    always_ff @(posedge core_clk_i) begin
        sync_d_r <= sync_s;
        if (dev_rst) begin
            since_edge_r <= 32'h0;
        end else if (sync_edge) begin
            since_edge_r <= 32'h1;
        end else begin
            since_edge_r <= (since_edge_r == PERIOD_LAST) ? 32'h0 : since_edge_r + 32'h1;
        end
    end

    // Writes drop pin alignment until a wake command rearms it
    always_ff @(posedge core_clk_i) begin
        if (dev_rst || !cont_s) begin
            armed_r <= 1'b0;
            pin_lost_r <= 1'b0;
        end else if (op_wake) begin
            armed_r <= 1'b0;
            pin_lost_r <= 1'b0;
        end else if (wr_resync) begin
            pin_lost_r <= 1'b1;
        end else if (first_edge) begin
            armed_r <= 1'b1;
        end
    end

    // Conversion sequencing
    asc_pkg::asc_conv_state_e state_r;
    logic [31:0] settle_r;
    logic [31:0] phase_r;
    wire settle_done = (state_r == asc_pkg::asc_st_settle) && (settle_r == 32'h0);
    wire period_end = (state_r == asc_pkg::asc_st_run) && (phase_r == PERIOD_LAST);
    wire tick = settle_done || period_end;
    wire leave_standby = (state_r == asc_pkg::asc_st_standby) && ser.cs_rise;
    wire restart = dev_rst || pulse_sync || op_wake || leave_standby;

    always_ff @(posedge core_clk_i) begin
        if (dev_rst) begin
            state_r <= asc_pkg::asc_st_settle;
            settle_r <= DR_CYC - 32'h1;
            phase_r <= 32'h0;
        end else if (op_standby) begin
            state_r <= asc_pkg::asc_st_standby;
        end else if (op_wake) begin
            state_r <= asc_pkg::asc_st_settle;
            settle_r <= WAKE_DR_CYC - 32'h1;
        end else if (leave_standby || pulse_sync) begin
            state_r <= asc_pkg::asc_st_settle;
            settle_r <= DR_CYC - 32'h1;
        end else begin
            unique case (state_r)
                asc_pkg::asc_st_settle: begin
                    if (settle_done) begin
                        state_r <= asc_pkg::asc_st_run;
                        phase_r <= 32'h0;
                    end else begin
                        settle_r <= settle_r - 32'h1;
                    end
                end
                asc_pkg::asc_st_run: begin
                    phase_r <= period_end ? 32'h0 : phase_r + 32'h1;
                end
                asc_pkg::asc_st_standby: begin
                    phase_r <= phase_r;
                end
                default: begin
                    state_r <= asc_pkg::asc_st_settle;
                end
            endcase
        end
    end

    // Two-entry buffer between filter output and the shifter
    logic [31:0] buf_mem [0:1];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] buf_cnt_r;
    logic ready_r;
    logic [2:0] upd_cnt_r;
    logic data_ready_n_r;
    logic [5:0] zero_reads_r;
    logic load_r;
    wire upd_end = (upd_cnt_r == 3'h1);
    wire buf_push = conv_valid_i && ready_r;
    wire buf_pop = upd_end && (buf_cnt_r != 2'h0) && !stop_continuous_read_cmd_r;
    wire flush = restart && !op_wake;
    wire [1:0] cnt_nxt = buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};

    always_ff @(posedge core_clk_i) begin
        if (buf_push) begin
            buf_mem[wr_ptr_r] <= conv_data_i;
        end
    end

    // Flush drops stale words with the filter memory
    always_ff @(posedge core_clk_i) begin
        if (flush) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            buf_cnt_r <= 2'h0;
            ready_r <= 1'b0;
        end else begin
            wr_ptr_r <= wr_ptr_r ^ buf_push;
            rd_ptr_r <= rd_ptr_r ^ buf_pop;
            buf_cnt_r <= cnt_nxt;
            ready_r <= (cnt_nxt != 2'h2);
        end
    end

    // Ready pulses high four clocks per update, falls when a word loads
    always_ff @(posedge core_clk_i) begin
        load_r <= 1'b0;
        if (restart || state_r != asc_pkg::asc_st_run) begin
            data_ready_n_r <= 1'b1;
            upd_cnt_r <= tick ? `ASC_UPDATE_CYC : 3'h0;
        end else if (tick) begin
            data_ready_n_r <= 1'b1;
            upd_cnt_r <= `ASC_UPDATE_CYC;
        end else if (upd_cnt_r != 3'h0) begin
            upd_cnt_r <= upd_cnt_r - 3'h1;
            if (upd_end) begin
                data_ready_n_r <= !buf_pop;
                load_r <= buf_pop;
            end
        end else if (ser.sclk_fall) begin
            data_ready_n_r <= 1'b1;
        end
    end

    // Resync output blanking counts data-ready periods, not clocks
    always_ff @(posedge core_clk_i) begin
        if (dev_rst || pulse_sync) begin
            zero_reads_r <= 6'h00;
        end else if (cont_resync) begin
            zero_reads_r <= `ASC_ZERO_READS;
        end else if (upd_end && zero_reads_r != 6'h00) begin
            zero_reads_r <= zero_reads_r - 6'h01;
        end
    end

    logic [31:0] tx_word_r;
    always_ff @(posedge core_clk_i) begin
        if (buf_pop) begin
            tx_word_r <= buf_mem[rd_ptr_r];
        end
    end

    assign ser.tx_load = load_r;
    assign ser.tx_word = tx_word_r;
    assign ser.tx_zero = (zero_reads_r != 6'h00);

    // Registered outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            data_ready_n_o <= 1'b1;
            filter_restart_o <= 1'b0;
            analog_en_o <= 1'b0;
            cfg_fir_o <= CFG_RST[`ASC_CFG_FIR_BIT];
            cfg_rate_o <= CFG_RST[2:0];
        end else begin
            data_ready_n_o <= data_ready_n_r;
            filter_restart_o <= restart || cont_resync;
            analog_en_o <= power_down_n_n_s && state_r != asc_pkg::asc_st_standby;
            cfg_fir_o <= cfg_r[`ASC_CFG_FIR_BIT];
            cfg_rate_o <= cfg_r[2:0];
        end
    end

    // Ready is the buffer's own flop, so push and ready agree on one edge
    assign conv_ready_o = ready_r;
endmodule

// ==== logic/asc_defines.svh ====
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
// Behaviour
// - Pulse sync from pin or command restarts conversion, flushes filter, holds ready high.
// - Continuous sync edge resyncs only if spacing is not whole conversion periods.
// - Continuous resync keeps ready toggling, forces serial output low for 63 periods.
// - Sync clock at a multiple of the data period causes no resync.
// - Host applies sync clock after mode select; first rising edge synchronises.
// - Register write in continuous sync mode resyncs and drops pin alignment.
// - Device stays in reset while reset pin is low.
// - Reset command acts three clocks after its eighth serial rising edge is detected.
// - Any reset restores register defaults and resynchronises conversions.
// - First data after reset: 62.98046875 data periods plus 468 clocks.
// - Power-down pin low disables circuitry, resets settings, outputs stay driven.
// - Standby by command keeps serial port and registers alive.
// - Chip select high ends standby.
// - Power-on and power-down release default to FIR at 1000 samples/s.
// - Wake command data-ready delay is two clocks shorter than pin wake.
// - Power-on reset ANDs supply-good flags, then counts 2^16 clocks.
// - Chip select high ignores serial clock, floats output, aborts transfers.
// - Rising chip select cancels stop-continuous-read mode.
// - Input bits sampled on serial rising edges, output changes on falling.

`define ASC_CLK_HZ 250000000
`define ASC_DEF_SPS 1000
`define ASC_DATA_PERIOD_CYC (`ASC_CLK_HZ / `ASC_DEF_SPS)
`define ASC_DR_PER_NUM 64'd6298046875
`define ASC_DR_PER_DEN 64'd100000000
`define ASC_DR_CLK_CYC 468
`define ASC_WAKE_TRIM_CYC 2
`define ASC_POR_CYC 65536
`define ASC_ZERO_READS 6'h3f
`define ASC_UPDATE_CYC 3'h4
`define ASC_WORD_BITS 32
`define ASC_OP_WAKE 8'h02
`define ASC_OP_STANDBY 8'h04
`define ASC_OP_RESET 8'h06
`define ASC_OP_SYNC 8'h08
`define ASC_OP_RDATAC 8'h10
`define ASC_OP_STOP_CONTINUOUS_READ_CMD 8'h11
`define ASC_OP_WREG 8'h40
`define ASC_CFG_FIR_BIT 3
`define ASC_CFG_RST 8'h0a
`endif

// ==== logic/asc_pkg.sv ====
package asc_pkg;
    typedef enum logic [1:0] {
        asc_st_settle = 2'b00,
        asc_st_run = 2'b01,
        asc_st_standby = 2'b10
    } asc_conv_state_e;
    typedef logic [7:0] asc_byte_t;
endpackage

// ==== logic/asc_ser_if.sv ====
`timescale 1ns/10ps
interface asc_ser_if;
    asc_pkg::asc_byte_t rx_byte;
    logic rx_vld;
    logic cs_rise;
    logic sclk_fall;
    logic tx_load;
    logic [31:0] tx_word;
    logic tx_zero;
    modport core (
        input rx_byte, rx_vld, cs_rise, sclk_fall,
        output tx_load, tx_word, tx_zero
    );
    modport port (
        output rx_byte, rx_vld, cs_rise, sclk_fall,
        input tx_load, tx_word, tx_zero
    );
endinterface

// ==== logic/asc_spi_port.sv ====
`timescale 1ns/10ps
`include "asc_defines.svh"
module asc_spi_port (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    // Core side
    asc_ser_if.port ser
);
    logic [2:0] pin_a_r;
    logic [2:0] pin_b_r;
    logic sclk_d_r;
    logic cs_d_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] rx_sh_r;
    logic [31:0] tx_sh_r;
    logic [5:0] tx_cnt_r;
    logic rx_vld_r;
    logic cs_rise_r;
    logic fall_r;

    // Serial clock is sampled, not used as a clock
    wire [2:0] pin_raw = {din_i, sclk_i, cs_n_i};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge core_clk_i) begin
                pin_a_r[gi] <= pin_raw[gi];
                pin_b_r[gi] <= pin_a_r[gi];
            end
        end
    endgenerate

    wire cs_hi = pin_b_r[0];
    wire sclk_s = pin_b_r[1];
    wire din_s = pin_b_r[2];
    wire rise = sclk_s & ~sclk_d_r & ~cs_hi;
    wire fall = ~sclk_s & sclk_d_r & ~cs_hi;
    wire cs_up = cs_hi & ~cs_d_r;
    wire [7:0] rx_next = {rx_sh_r[6:0], din_s};

    always_ff @(posedge core_clk_i) begin
        sclk_d_r <= sclk_s;
        cs_d_r <= cs_hi;
        cs_rise_r <= cs_hi & ~cs_d_r;
        fall_r <= fall;
    end

    // Receive: one byte per eight rising edges; a high select aborts it
    always_ff @(posedge core_clk_i) begin
        rx_vld_r <= 1'b0;
        if (rst_i || cs_hi) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 8'h00;
        end else if (rise) begin
            rx_sh_r <= rx_next;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_vld_r <= (bit_cnt_r == 3'h7);
        end
    end

    // Transmit: MSB shows at load, next bit on each falling edge
    // A word loaded while deselected waits for the next select
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tx_cnt_r <= 6'h00;
            tx_sh_r <= 32'h0;
            dout_o <= 1'b0;
        end else if (ser.tx_load) begin
            tx_sh_r <= ser.tx_word;
            tx_cnt_r <= 6'h20;
            dout_o <= ser.tx_word[31] & ~ser.tx_zero;
        end else if (cs_up) begin
            tx_cnt_r <= 6'h00;
            tx_sh_r <= 32'h0;
            dout_o <= 1'b0;
        end else if (fall) begin
            tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            tx_cnt_r <= (tx_cnt_r == 6'h00) ? 6'h00 : tx_cnt_r - 6'h01;
            dout_o <= (tx_cnt_r > 6'h01) & tx_sh_r[30] & ~ser.tx_zero;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dout_oe_o <= 1'b0;
        end else begin
            dout_oe_o <= ~cs_hi;
        end
    end

    assign ser.rx_byte = rx_sh_r;
    assign ser.rx_vld = rx_vld_r;
    assign ser.cs_rise = cs_rise_r;
    assign ser.sclk_fall = fall_r;
endmodule
